// >>> hw/cmsc_pkg.sv
// Package of constants and carrier types for the core memory select and cycle block
package cmsc_pkg;

  // ----------------------------------------------------------------
  // Address field positions
  // ----------------------------------------------------------------
  localparam int Y_GROUP_LSB = 0;
  localparam int Y_LINE_LSB  = 3;
  localparam int X_GROUP_LSB = 6;
  localparam int X_LINE_LSB  = 9;
  localparam int STACK_LSB   = 12;
  localparam int BANK_LSB    = 14;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 16;
  localparam int WORD_W  = 18;
  localparam int NBANK   = 4;
  localparam int NSTACK  = 4;
  localparam int NSEL    = 8;

  // ----------------------------------------------------------------
  // Phase lengths, strobe cycle and counter reset value, in clock cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] READ_CYC   = 4'h4;
  localparam logic [3:0] STROBE_AT  = 4'h2;
  localparam logic [3:0] WRITE_CYC  = 4'h4;
  localparam logic [3:0] CNT_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMSC_IDLE  = 3'h1,
    CMSC_READ  = 3'h2,
    CMSC_WRITE = 3'h4
  } cmsc_state_t;

  typedef struct packed {
    logic [NBANK-1:0]  bank_en;
    logic [NSTACK-1:0] stack_en;
    logic [NSEL-1:0]   x_group;
    logic [NSEL-1:0]   x_line;
    logic [NSEL-1:0]   y_group;
    logic [NSEL-1:0]   y_line;
    logic              read_pulse;
    logic              write_pulse;
  } cmsc_drive_t;

  typedef struct packed {
    logic              start;
    logic              new_word;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } cmsc_req_t;

  typedef struct packed {
    cmsc_state_t       state;
    logic [3:0]        cnt;
    logic [ADDR_W-1:0] memory_address_register;
    logic [WORD_W-1:0] memory_data_register;
    logic [WORD_W-1:0] bank_read_latch;
    logic              new_word;
    logic              initiate;
    logic              timing_run;
    logic              busy;
    logic              done;
    logic              sense_strobe;
    cmsc_drive_t       drv;
    logic [WORD_W-1:0] inhibit;
  } cmsc_regs_t;

endpackage

// >>> hw/cmsc_core.sv
// Main-memory select decode and read/rewrite cycle sequencer
// Summary of operation
// - Read drives core to zero, sense captures
// - Every read followed by write, same location
// - Write pulses X/Y; inhibit zero bits
// - Either sense polarity counts as one
// - Address bits 9-11 pick X line
// - Address bits 6-8 pick X group
// - Bits 12-13 pick stack, bank qualified
// - Y group bits 0-2, line 3-5
// - Drive pulses need enable and bank enable
// - Start launches timing and initiates latch
// - Identical decode per bank, enables differ
// - X selections only during address enable
// - Bits 14-15 pick one of four banks
// - Data register zeros enable inhibit drive
module cmsc_core (
  input  wire logic                            clk_in,
  input  wire logic                            rstn_in,
  input  wire cmsc_pkg::cmsc_req_t             req_in,
  input  wire logic [cmsc_pkg::WORD_W-1:0]     sense_pos_in,
  input  wire logic [cmsc_pkg::WORD_W-1:0]     sense_neg_in,
  output logic                                 busy_out,
  output logic                                 done_out,
  output logic                                 initiate_out,
  output logic                                 timing_run_out,
  output logic                                 sense_strobe_out,
  output cmsc_pkg::cmsc_drive_t                drive_out,
  output logic [cmsc_pkg::WORD_W-1:0]          inhibit_out,
  output logic [cmsc_pkg::WORD_W-1:0]          rdata_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cmsc_pkg::cmsc_regs_t r_ff;
  cmsc_pkg::cmsc_regs_t nxt_r;

  logic [cmsc_pkg::NBANK-1:0]  bank_dec;
  logic [cmsc_pkg::NSTACK-1:0] stack_dec;
  logic [cmsc_pkg::NSEL-1:0]   xg_dec;
  logic [cmsc_pkg::NSEL-1:0]   xl_dec;
  logic [cmsc_pkg::NSEL-1:0]   yg_dec;
  logic [cmsc_pkg::NSEL-1:0]   yl_dec;
  logic                        addr_en;
  logic [cmsc_pkg::WORD_W-1:0] sensed;

  // ----------------------------------------------------------------
  // Address decode, shared by every bank
  // ----------------------------------------------------------------
  logic [cmsc_pkg::ADDR_W-1:0] a;
  // Taken address on the start edge, held address otherwise
  assign a = ((r_ff.state == cmsc_pkg::CMSC_IDLE) && req_in.start) ? req_in.addr
                                                                   : r_ff.memory_address_register;

  always_comb begin
    bank_dec  = '0;
    stack_dec = '0;
    xg_dec    = '0;
    xl_dec    = '0;
    yg_dec    = '0;
    yl_dec    = '0;
    bank_dec[a[cmsc_pkg::BANK_LSB +: 2]]     = 1'b1;
    stack_dec[a[cmsc_pkg::STACK_LSB +: 2]]   = 1'b1;
    xl_dec[a[cmsc_pkg::X_LINE_LSB +: 3]]     = 1'b1;
    xg_dec[a[cmsc_pkg::X_GROUP_LSB +: 3]]    = 1'b1;
    yg_dec[a[cmsc_pkg::Y_GROUP_LSB +: 3]]    = 1'b1;
    yl_dec[a[cmsc_pkg::Y_LINE_LSB +: 3]]     = 1'b1;
  end

  // Either polarity of a sense pulse reads as one
  assign sensed = sense_pos_in | sense_neg_in;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.sense_strobe = 1'b0;
    nxt_r.initiate = 1'b0;
    nxt_r.done     = 1'b0;
    unique case (r_ff.state)
      cmsc_pkg::CMSC_IDLE: begin
        if (req_in.start) begin
          nxt_r.state      = cmsc_pkg::CMSC_READ;
          nxt_r.cnt        = cmsc_pkg::CNT_RESET;
          nxt_r.memory_address_register = req_in.addr;
          nxt_r.new_word   = req_in.new_word;
          nxt_r.memory_data_register = req_in.wdata;
          nxt_r.initiate   = 1'b1;
          nxt_r.timing_run = 1'b1;
          nxt_r.busy       = 1'b1;
          nxt_r.bank_read_latch = '0;
        end
      end
      cmsc_pkg::CMSC_READ: begin
        nxt_r.cnt = r_ff.cnt + 4'h1;
        if (r_ff.cnt == cmsc_pkg::STROBE_AT) begin
          nxt_r.sense_strobe = 1'b1;
          nxt_r.bank_read_latch = sensed;
        end
        if (r_ff.cnt == cmsc_pkg::READ_CYC - 4'h1) begin
          nxt_r.state = cmsc_pkg::CMSC_WRITE;
          nxt_r.cnt   = cmsc_pkg::CNT_RESET;
          if (!r_ff.new_word) begin
            nxt_r.memory_data_register = r_ff.bank_read_latch;
          end
        end
      end
      cmsc_pkg::CMSC_WRITE: begin
        nxt_r.cnt = r_ff.cnt + 4'h1;
        if (r_ff.cnt == cmsc_pkg::WRITE_CYC - 4'h1) begin
          nxt_r.state      = cmsc_pkg::CMSC_IDLE;
          nxt_r.cnt        = cmsc_pkg::CNT_RESET;
          nxt_r.timing_run = 1'b0;
          nxt_r.busy       = 1'b0;
          nxt_r.done       = 1'b1;
        end
      end
      default: begin
        nxt_r.state = cmsc_pkg::CMSC_IDLE;
      end
    endcase

    // Drive outputs follow the next phase, gated by the address enable; stack enables and pulses also by bank enables
    addr_en = (nxt_r.state != cmsc_pkg::CMSC_IDLE);
    nxt_r.drv.bank_en     = addr_en ? bank_dec : '0;
    nxt_r.drv.stack_en    = (addr_en && (|bank_dec)) ? stack_dec : '0;
    nxt_r.drv.x_group     = addr_en ? xg_dec : '0;
    nxt_r.drv.x_line      = addr_en ? xl_dec : '0;
    nxt_r.drv.y_group     = addr_en ? yg_dec : '0;
    nxt_r.drv.y_line      = addr_en ? yl_dec : '0;
    nxt_r.drv.read_pulse  = (nxt_r.state == cmsc_pkg::CMSC_READ) && (|nxt_r.drv.bank_en);
    nxt_r.drv.write_pulse = (nxt_r.state == cmsc_pkg::CMSC_WRITE) && (|nxt_r.drv.bank_en);
    nxt_r.inhibit = (nxt_r.state == cmsc_pkg::CMSC_WRITE) ?
                    ~nxt_r.memory_data_register : '0;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_ff       <= '{state: cmsc_pkg::CMSC_IDLE, cnt: cmsc_pkg::CNT_RESET, default: '0};
    end else begin
      r_ff       <= nxt_r;
    end
  end

  assign busy_out         = r_ff.busy;
  assign done_out         = r_ff.done;
  assign initiate_out     = r_ff.initiate;
  assign timing_run_out   = r_ff.timing_run;
  assign sense_strobe_out = r_ff.sense_strobe;
  assign drive_out        = r_ff.drv;
  assign inhibit_out      = r_ff.inhibit;
  assign rdata_out        = r_ff.bank_read_latch;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_read_then_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(r_ff.drv.read_pulse) |-> r_ff.drv.write_pulse)
    else $error("read not followed by write");
  a_pulse_exclusive: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(r_ff.drv.read_pulse && r_ff.drv.write_pulse) && ((r_ff.drv.read_pulse ||
      r_ff.drv.write_pulse) -> (|r_ff.drv.bank_en)))
    else $error("drive pulse without bank enable");
  a_inhibit_zeros: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.drv.write_pulse |-> (r_ff.inhibit == ~r_ff.memory_data_register))
    else $error("inhibit does not match zero bits");
  a_no_inhibit_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !r_ff.drv.write_pulse |-> (r_ff.inhibit == '0))
    else $error("inhibit outside write");
  a_start_launch: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (req_in.start && r_ff.state == cmsc_pkg::CMSC_IDLE) |=> initiate_out && timing_run_out
      && r_ff.drv.read_pulse)
    else $error("start did not launch cycle");
  a_bank_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.busy |-> r_ff.drv.bank_en == (4'h1 << r_ff.memory_address_register[15:14]))
    else $error("bank decode wrong");
  a_x_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.busy |-> (r_ff.drv.x_line == (8'h01 << r_ff.memory_address_register[11:9]))
      && (r_ff.drv.x_group == (8'h01 << r_ff.memory_address_register[8:6])))
    else $error("x decode wrong");
  a_y_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.busy |-> (r_ff.drv.y_group == (8'h01 << r_ff.memory_address_register[2:0]))
      && (r_ff.drv.y_line == (8'h01 << r_ff.memory_address_register[5:3])))
    else $error("y decode wrong");
  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !r_ff.busy |-> (r_ff.drv.x_group == '0) && (r_ff.drv.stack_en == '0))
    else $error("selection outside cycle");
  a_rewrite_word: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($rose(r_ff.drv.write_pulse) && !r_ff.new_word) |->
      r_ff.memory_data_register == $past(r_ff.bank_read_latch))
    else $error("read word not restored");
  a_strobe_in_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.sense_strobe |-> r_ff.drv.read_pulse)
    else $error("sense strobe outside read phase");
  a_sense_capture: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(r_ff.sense_strobe) |-> (r_ff.bank_read_latch == $past(sensed)))
    else $error("sense pulses not captured as ones");
  a_cycle_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(r_ff.drv.read_pulse) |-> r_ff.drv.read_pulse [*4] ##1
      r_ff.drv.write_pulse [*4] ##1 done_out)
    else $error("read not followed by full write phase");
  a_stack_decode: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.busy |-> (r_ff.drv.stack_en == (4'h1 << r_ff.memory_address_register[13:12])))
    else $error("stack decode wrong");
  a_initiate_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    initiate_out |-> r_ff.drv.read_pulse ##1 !initiate_out)
    else $error("initiate not a single pulse at read start");
  a_done_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
    done_out |-> !busy_out && (r_ff.drv == '0) && (r_ff.inhibit == '0))
    else $error("drive left active after cycle end");
  a_write_location: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(r_ff.drv.write_pulse) |-> $stable(r_ff.drv.bank_en) && $stable(r_ff.drv.stack_en)
      && $stable(r_ff.drv.x_line) && $stable(r_ff.drv.y_line))
    else $error("write phase moved to another location");
  a_idle_no_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !r_ff.busy |-> !r_ff.drv.read_pulse && !r_ff.drv.write_pulse)
    else $error("drive pulse outside cycle");
  a_bank_onehot: assert property (@(posedge clk_in) disable iff (!rstn_in)
    r_ff.busy |-> $onehot(r_ff.drv.bank_en))
    else $error("more or fewer than one bank enabled");

endmodule

// >>> tb/cmsc_core_array_model.sv
// Behavioural model of the core stacks seen through drive, inhibit and sense lines
module cmsc_core_array_model (
  input  wire logic                        clk_in,
  input  wire cmsc_pkg::cmsc_drive_t       drive_in,
  input  wire logic [cmsc_pkg::WORD_W-1:0] inhibit_in,
  output logic [cmsc_pkg::WORD_W-1:0]      sense_pos_out,
  output logic [cmsc_pkg::WORD_W-1:0]      sense_neg_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [17:0] mem [int];
  logic [15:0] idx;
  logic [17:0] rd_word = 18'h0;
  logic        rd_d = 1'b0;
  logic        wr_d = 1'b0;

  function automatic logic [2:0] oh2i(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Location from the one-hot selections
  // ----------------------------------------------------------------
  always @* begin
    idx = {2'(oh2i({4'h0, drive_in.bank_en})), 2'(oh2i({4'h0, drive_in.stack_en})),
           oh2i(drive_in.x_line), oh2i(drive_in.x_group),
           oh2i(drive_in.y_line), oh2i(drive_in.y_group)};
  end

  // Sense pulses of mixed polarity for stored ones, none when not reading
  always @(negedge clk_in) begin
    if (drive_in.read_pulse && rd_d) begin
      sense_pos_out <= rd_word & 18'h15555;
      sense_neg_out <= rd_word & 18'h2aaaa;
    end else begin
      sense_pos_out <= 18'h0;
      sense_neg_out <= 18'h0;
    end
  end

  // Inhibited planes keep zero, the rest switch to one
  always @(posedge clk_in) begin
    if (drive_in.read_pulse && !rd_d) begin
      rd_word = mem.exists(idx) ? mem[idx] : 18'h0;
      mem[idx] = 18'h0; // Reading switches every addressed core to zero
    end
    if (drive_in.write_pulse && !wr_d) mem[idx] = ~inhibit_in;
    wr_d <= drive_in.write_pulse;
    rd_d <= drive_in.read_pulse;
  end
endmodule

// >>> tb/cmsc_core_tb_top.sv
// Testbench for the core memory select and cycle block
module cmsc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_in;
  logic                  rstn_in;
  cmsc_pkg::cmsc_req_t   req;
  cmsc_pkg::cmsc_drive_t drive;
  logic [17:0]           sense_pos, sense_neg, inhibit, rdata;
  logic                  busy, done, initiate, timing_run, strobe;
  int                    miscompares;
  int                    num_checks;
  logic [15:0]           addrs [8];
  logic [17:0]           words [8];

  cmsc_core u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req),
    .sense_pos_in(sense_pos), .sense_neg_in(sense_neg), .busy_out(busy), .done_out(done),
    .initiate_out(initiate), .timing_run_out(timing_run), .sense_strobe_out(strobe),
    .drive_out(drive), .inhibit_out(inhibit), .rdata_out(rdata));

  cmsc_core_array_model u_model (.clk_in(clk_in), .drive_in(drive), .inhibit_in(inhibit),
    .sense_pos_out(sense_pos), .sense_neg_out(sense_neg));

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One full cycle; a second start during the read phase must be ignored
  task automatic run(input logic [15:0] a, input logic nw, input logic [17:0] wd,
                     input logic [17:0] er);
    cmsc_pkg::cmsc_drive_t e;
    e = '0;
    e.bank_en = 4'h1 << a[15:14];
    e.stack_en = 4'h1 << a[13:12];
    e.x_line = 8'h1 << a[11:9];
    e.x_group = 8'h1 << a[8:6];
    e.y_line = 8'h1 << a[5:3];
    e.y_group = 8'h1 << a[2:0];
    e.read_pulse = 1'b1;
    req = '{start: 1'b1, new_word: nw, addr: a, wdata: wd};
    @(negedge clk_in);
    req.start = 1'b0;
    check("busy_init_run", 64'({busy, initiate, timing_run, done}), 64'h0e);
    check("read_drive", 64'(drive), 64'(e));
    @(negedge clk_in);
    req.start = 1'b1;
    req.addr = ~a;
    check("initiate_pulse", 64'(initiate), 64'h0);
    @(negedge clk_in);
    req.start = 1'b0;
    @(negedge clk_in);
    check("strobe", 64'(strobe), 64'h1);
    @(negedge clk_in);
    e.read_pulse = 1'b0;
    e.write_pulse = 1'b1;
    check("write_drive", 64'(drive), 64'(e));
    check("inhibit", 64'(inhibit), 64'(18'(~(nw ? wd : er))));
    repeat (4) @(negedge clk_in);
    check("done_idle", 64'({busy, done, timing_run}), 64'h2);
    check("idle_drive", 64'(drive), 64'h0);
    check("rdata", 64'(rdata), 64'(er));
  endtask

  task automatic t_write_all();
    for (int i = 0; i < 8; i++) run(addrs[i], 1'b1, words[i], 18'h0);
  endtask

  task automatic t_rewrite_all();
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8; i++) run(addrs[i], 1'b0, 18'h0, words[i]);
    end
  endtask

  task automatic t_replace();
    run(addrs[0], 1'b1, 18'h2468a, words[0]);
    run(addrs[0], 1'b0, 18'h0, 18'h2468a);
  endtask

  task automatic t_reset_abort();
    req = '{start: 1'b1, new_word: 1'b1, addr: addrs[1], wdata: 18'h0};
    @(negedge clk_in);
    req.start = 1'b0;
    @(negedge clk_in);
    rstn_in = 1'b0;
    #1;
    check("reset_flags", 64'({busy, initiate, timing_run, done, strobe}), 64'h0);
    check("reset_drive", 64'(drive), 64'h0);
    @(negedge clk_in);
    rstn_in = 1'b1;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    #200us;
    miscompares++;
    finish_test();
  end

  initial begin
    miscompares = 0;
    num_checks = 0;
    rstn_in = 1'b0;
    req = '0;
    for (int i = 0; i < 8; i++) begin
      addrs[i] = {2'(i), 2'(i + 1), 3'(i), 3'(i + 3), 3'(7 - i), 3'(i + 5)};
    end
    words = '{18'h3ffff, 18'h00000, 18'h15555, 18'h2aaaa,
              18'h12345, 18'h0f0f0, 18'h30c3f, 18'h00001};
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    t_write_all();
    t_reset_abort();
    t_rewrite_all();
    t_replace();
    finish_test();
  end
endmodule
